//--- cmit_can_node.sv
// Far-side CAN node sharing the wired-AND bus line
`timescale 1ns/1ns
module cmit_can_node (
   input  wire logic transmit_pin, // Our transmit pin
   input  wire logic node_drv,     // Node bit, 0 dominant
   output logic      receive_pin   // Bus level seen back
);
   // Dominant level from either side wins the bus
   assign receive_pin = transmit_pin & node_drv;
endmodule : cmit_can_node

//--- cmit_pkg.sv
// Constants shared by the mailbox support block and its users
package cmit_pkg;

   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [7:0] OFS_IRQ_LINE   = 8'h00; // Line select per mbox
   localparam logic [7:0] OFS_PROTECT    = 8'h04; // Overwrite protection
   localparam logic [7:0] OFS_TX_PIN     = 8'h08; // Transmit pin control
   localparam logic [7:0] OFS_RX_PIN     = 8'h0C; // Receive pin control
   localparam logic [7:0] OFS_STAMP_CNT  = 8'h10; // Time-stamp counter
   localparam logic [7:0] OFS_MASTER     = 8'h14; // Master control bits
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h18; // Mailbox irq mask
   localparam logic [7:0] OFS_RX_LOST    = 8'h1C; // Receive-lost, W1C
   localparam logic [7:0] OFS_STAMP_BASE = 8'h80; // 32 mailbox stamps

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int PIN_FUNC_BIT   = 3;  // Pin function enable bit
   localparam int MSB_CLEAR_BIT  = 14; // Write 1 clears counter MSB
   localparam int MB16_CLEAR_BIT = 15; // Mailbox 16 clears counter
   localparam int SYNC_MBOX      = 16; // Mailbox used for time sync

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [31:0] RST_IRQ_LINE  = 32'h0000_0000;
   localparam logic [31:0] RST_PROTECT   = 32'h0000_0000;
   localparam logic        RST_PIN_FUNC  = 1'b0;
   localparam logic [31:0] RST_STAMP_CNT = 32'h0000_0000;
   localparam logic        RST_MB16_EN   = 1'b0;
   localparam logic [31:0] RST_IRQ_MASK  = 32'h0000_0000;
   localparam logic [31:0] RST_RX_LOST   = 32'h0000_0000;
   localparam logic [31:0] RST_STAMP     = 32'h0000_0000;

   // ****************************************************************
   // Bus answers and sizes
   // ****************************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0; // Normal answer
   localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped or refused
   localparam logic [3:0] STRB_FULL   = 4'hF; // Full word access
   localparam int         NUM_MBOX    = 32;   // Mailboxes served

endpackage : cmit_pkg

//--- cmit_support.sv
// Mailbox interrupt routing, overwrite protection, pins and time stamps
`timescale 1ns/1ns
module cmit_support (
   input  wire logic        aclk,                 // System clock 100 MHz
   input  wire logic        aresetn,              // Sync reset, low
   // AXI4-Lite register port
   input  wire logic [7:0]  s_axi_awaddr,         // Write address
   input  wire logic        s_axi_awvalid,        // Write address valid
   output logic             s_axi_awready,        // Write address ready
   input  wire logic [31:0] s_axi_wdata,          // Write data
   input  wire logic [3:0]  s_axi_wstrb,          // Write byte strobes
   input  wire logic        s_axi_wvalid,         // Write data valid
   output logic             s_axi_wready,         // Write data ready
   output logic [1:0]       s_axi_bresp,          // Write answer code
   output logic             s_axi_bvalid,         // Write answer valid
   input  wire logic        s_axi_bready,         // Write answer ready
   input  wire logic [7:0]  s_axi_araddr,         // Read address
   input  wire logic        s_axi_arvalid,        // Read address valid
   output logic             s_axi_arready,        // Read address ready
   output logic [31:0]      s_axi_rdata,          // Read data
   output logic [1:0]       s_axi_rresp,          // Read answer code
   output logic             s_axi_rvalid,         // Read answer valid
   input  wire logic        s_axi_rready,         // Read answer ready
   // Mode levels from the controller core
   input  wire logic        protected_write_mode, // Guarded writes open
   input  wire logic        standard_compat_mode, // Compatibility mode
   input  wire logic        init_mode,            // Initialization mode
   input  wire logic        sleep_mode,           // Sleep mode
   input  wire logic        suspend_mode,         // Suspend mode
   input  wire logic        can_sm_busy,          // Protocol owns regs
   input  wire logic        bit_tick,             // One pulse per bit
   input  wire logic [31:0] mailbox_direction,    // 1 = receive mbox
   // Receive store request from the protocol engine
   input  wire logic        rx_store_req,         // Good frame, pulse
   input  wire logic [31:0] rx_match_mask,        // Mailboxes matching
   input  wire logic [31:0] receive_pending_bit,  // Mailboxes full
   output logic             rx_store_valid,       // Store granted
   output logic [4:0]       rx_store_mbox,        // Mailbox to store
   output logic             rx_discard,           // Frame dropped
   // Transmit completion from the protocol engine
   input  wire logic        tx_done,              // Sent ok, pulse
   input  wire logic [4:0]  tx_mbox,              // Mailbox that sent
   // Pins
   input  wire logic        engine_tx,            // Bit from engine
   output logic             engine_rx,            // Bit to engine
   output logic             transmit_pin,         // CAN transmit pin
   input  wire logic        receive_pin,          // CAN receive pin
   // Events
   output logic             interrupt_line_zero,  // Mailbox irq line 0
   output logic             interrupt_line_one,   // Mailbox irq line 1
   output logic             counter_overflow_flag // Overflow set pulse
);
   import cmit_pkg::*;

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [31:0] irq_line_r;        // Line choice per mailbox
   logic [31:0] protect_r;         // Overwrite protection per mailbox
   logic        tx_func_r;         // Transmit pin handed to CAN
   logic        rx_func_r;         // Receive pin handed to CAN
   logic [31:0] stamp_cnt_r;       // Free-running time-stamp counter
   logic [31:0] stamp_cnt_nxt;     // Next counter value
   logic        mb16_en_r;         // Mailbox 16 clears the counter
   logic [31:0] irq_mask_r;        // Mailbox interrupt mask
   logic [31:0] rx_lost_r;         // Receive-lost bits
   logic [31:0] stamp_r [NUM_MBOX];// Per-mailbox time stamps
   logic        msb_prev_r;        // Counter MSB one cycle back
   logic        msb_pend_r;        // MSB clear waiting for access
   logic        full_pend_r;       // Full clear waiting for access

   // ****************************************************************
   // Write channel holding
   // ****************************************************************
   logic        aw_have_r;         // Write address captured
   logic [7:0]  aw_addr_r;         // Captured write address
   logic        w_have_r;          // Write data captured
   logic [31:0] w_data_r;          // Captured write data
   logic [3:0]  w_strb_r;          // Captured strobes
   logic        bvalid_r;          // Write answer pending
   logic [1:0]  bresp_r;           // Write answer code
   logic        rvalid_r;          // Read answer pending
   logic [31:0] rdata_r;           // Read answer data
   logic [1:0]  rresp_r;           // Read answer code

   // Merge strobed bytes into an old word
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   // ****************************************************************
   // Receive search
   // ****************************************************************
   logic        found_c;           // A mailbox will take the frame
   logic [4:0]  found_idx_c;       // Chosen mailbox
   logic        found_ovw_c;       // Chosen mailbox was full

   // Lowest matching mailbox that is empty or not protected wins
   always_comb begin
      found_c     = 1'b0;
      found_idx_c = 5'h00;
      found_ovw_c = 1'b0;
      for (int i = 0; i < NUM_MBOX; i++) begin
         if (!found_c && rx_match_mask[i]) begin
            if (!receive_pending_bit[i] || !protect_r[i]) begin
               found_c     = 1'b1;
               found_idx_c = i[4:0];
               found_ovw_c = receive_pending_bit[i];
            end
         end
      end
   end

   // Registered grant towards the engine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_store_valid <= 1'b0;
         rx_store_mbox  <= 5'h00;
         rx_discard     <= 1'b0;
      end else begin
         rx_store_valid <= rx_store_req && found_c;
         rx_store_mbox  <= found_idx_c;
         rx_discard     <= rx_store_req && !found_c;
      end
   end

   // Overwrite flag pulse per mailbox, one cycle after the request
   logic [31:0] lost_set_r;        // Mailboxes overwritten now
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lost_set_r <= 32'h0000_0000;
      end else begin
         lost_set_r <= (rx_store_req && found_c && found_ovw_c) ?
                       (32'h0000_0001 << found_idx_c) : 32'h0000_0000;
      end
   end

   // ****************************************************************
   // Mailbox events and interrupt lines
   // ****************************************************************
   wire [31:0] rx_evt = rx_store_valid ?
                        (32'h0000_0001 << rx_store_mbox) : 32'h0000_0000;
   wire [31:0] tx_evt = tx_done ?
                        (32'h0000_0001 << tx_mbox) : 32'h0000_0000;
   wire [31:0] irq_evt = (rx_evt | tx_evt) & irq_mask_r;

   // Lines are pulses; flag keeping lives with the global flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interrupt_line_zero <= 1'b0;
         interrupt_line_one  <= 1'b0;
      end else begin
         interrupt_line_zero <= |(irq_evt & ~irq_line_r);
         interrupt_line_one  <= |(irq_evt & irq_line_r);
      end
   end

   // ****************************************************************
   // Pins
   // ****************************************************************
   logic [2:0] rx_sync_r;          // Receive pin synchroniser
   logic       rx_level_r;         // Accepted receive level

   // Three stages; a level counts once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_sync_r  <= 3'h7;
         rx_level_r <= 1'b1;
      end else begin
         rx_sync_r <= {rx_sync_r[1:0], receive_pin};
         if (rx_sync_r[1] == rx_sync_r[2]) begin
            rx_level_r <= rx_sync_r[2];
         end
      end
   end

   // Recessive level whenever a pin is not handed to CAN
   assign transmit_pin = tx_func_r ? engine_tx : 1'b1;
   assign engine_rx    = rx_func_r ? rx_level_r : 1'b1;

   // ****************************************************************
   // Bus write decode
   // ****************************************************************
   wire cap_busy = rx_store_valid || tx_done; // Stamp port in use
   // Protocol captures own the stamp port; bus writes wait a cycle
   wire wr_go    = aw_have_r && w_have_r && !bvalid_r && !cap_busy;
   wire wr_stamp = aw_addr_r[7] && (aw_addr_r[1:0] == 2'h0);
   wire [4:0] wr_idx = aw_addr_r[6:2];
   wire wr_line  = (aw_addr_r == OFS_IRQ_LINE);
   wire wr_prot  = (aw_addr_r == OFS_PROTECT);
   wire wr_txp   = (aw_addr_r == OFS_TX_PIN);
   wire wr_rxp   = (aw_addr_r == OFS_RX_PIN);
   wire wr_cnt   = (aw_addr_r == OFS_STAMP_CNT);
   wire wr_mst   = (aw_addr_r == OFS_MASTER);
   wire wr_mask  = (aw_addr_r == OFS_IRQ_MASK);
   wire wr_lost  = (aw_addr_r == OFS_RX_LOST);
   wire wr_hit   = wr_line || wr_prot || wr_txp || wr_rxp || wr_cnt ||
                   wr_mst || wr_mask || wr_lost || wr_stamp;
   // Partial protection writes are refused as a whole
   wire wr_prot_ok = wr_prot && (w_strb_r == STRB_FULL);
   wire wr_cnt_ok  = wr_cnt && protected_write_mode &&
                     !standard_compat_mode;
   wire [31:0] wr_word = w_data_r;
   wire msb_clr_wr = wr_go && wr_mst && w_strb_r[1] &&
                     wr_word[MSB_CLEAR_BIT];
   wire wr_err = !wr_hit || (wr_prot && !wr_prot_ok);

   // Address and data accepted in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_have_r  <= 1'b0;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_have_r) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_have_r <= 1'b0;
         end
         if (s_axi_wvalid && !w_have_r) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (wr_go) begin
            w_have_r <= 1'b0;
         end
      end
   end

   // Write answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ****************************************************************
   // Control registers
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_line_r <= RST_IRQ_LINE;
         protect_r  <= RST_PROTECT;
         tx_func_r  <= RST_PIN_FUNC;
         rx_func_r  <= RST_PIN_FUNC;
         mb16_en_r  <= RST_MB16_EN;
         irq_mask_r <= RST_IRQ_MASK;
      end else if (wr_go) begin
         if (wr_line) begin
            irq_line_r <= merge_bytes(irq_line_r, wr_word, w_strb_r);
         end
         if (wr_prot_ok) begin
            protect_r <= wr_word;
         end
         // Only the function bit is kept; the rest is dropped
         if (wr_txp && protected_write_mode && w_strb_r[0]) begin
            tx_func_r <= wr_word[PIN_FUNC_BIT];
         end
         if (wr_rxp && protected_write_mode && w_strb_r[0]) begin
            rx_func_r <= wr_word[PIN_FUNC_BIT];
         end
         if (wr_mst && w_strb_r[1]) begin
            mb16_en_r <= wr_word[MB16_CLEAR_BIT];
         end
         if (wr_mask) begin
            irq_mask_r <= merge_bytes(irq_mask_r, wr_word, w_strb_r);
         end
      end
   end

   // Lost bits: hardware set beats a software clear
   wire [31:0] lost_clr = (wr_go && wr_lost) ?
                          merge_bytes(32'h0000_0000, wr_word, w_strb_r) :
                          32'h0000_0000;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_lost_r <= RST_RX_LOST;
      end else begin
         rx_lost_r <= (rx_lost_r & ~lost_clr) | lost_set_r;
      end
   end

   // ****************************************************************
   // Time-stamp counter
   // ****************************************************************
   wire halt     = init_mode || sleep_mode || suspend_mode;
   wire sync_rx  = rx_store_valid && (rx_store_mbox == 5'(SYNC_MBOX)) &&
                   mailbox_direction[SYNC_MBOX];
   wire sync_tx  = tx_done && (tx_mbox == 5'(SYNC_MBOX)) &&
                   !mailbox_direction[SYNC_MBOX];
   wire sync_clr = mb16_en_r && (sync_rx || sync_tx);

   // Clear requests wait while the protocol machine holds the regs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         msb_pend_r  <= 1'b0;
         full_pend_r <= 1'b0;
      end else if (!can_sm_busy) begin
         msb_pend_r  <= 1'b0;
         full_pend_r <= 1'b0;
      end else begin
         msb_pend_r  <= msb_pend_r || msb_clr_wr;
         full_pend_r <= full_pend_r || sync_clr;
      end
   end

   wire do_full = !can_sm_busy && (full_pend_r || sync_clr);
   wire do_msb  = !can_sm_busy && (msb_pend_r || msb_clr_wr);

   // Bus write beats tick; clears beat both
   always_comb begin
      stamp_cnt_nxt = stamp_cnt_r;
      if (bit_tick && !halt) begin
         stamp_cnt_nxt = stamp_cnt_r + 32'h0000_0001;
      end
      if (wr_go && wr_cnt_ok) begin
         stamp_cnt_nxt = merge_bytes(stamp_cnt_r, wr_word, w_strb_r);
      end
      if (do_msb) begin
         stamp_cnt_nxt[31] = 1'b0;
      end
      if (do_full) begin
         stamp_cnt_nxt = 32'h0000_0000;
      end
   end

   // Counter and overflow edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stamp_cnt_r           <= RST_STAMP_CNT;
         msb_prev_r            <= 1'b0;
         counter_overflow_flag <= 1'b0;
      end else begin
         stamp_cnt_r           <= stamp_cnt_nxt;
         msb_prev_r            <= stamp_cnt_r[31];
         counter_overflow_flag <= stamp_cnt_r[31] && !msb_prev_r;
      end
   end

   // ****************************************************************
   // Mailbox stamps
   // ****************************************************************
   // Capture on stored receive and on finished transmit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_MBOX; i++) begin
            stamp_r[i] <= RST_STAMP;
         end
      end else begin
         if (wr_go && wr_stamp) begin
            stamp_r[wr_idx] <= merge_bytes(stamp_r[wr_idx], wr_word,
                                           w_strb_r);
         end
         if (rx_store_valid) begin
            stamp_r[rx_store_mbox] <= stamp_cnt_r;
         end
         if (tx_done) begin
            stamp_r[tx_mbox] <= stamp_cnt_r;
         end
      end
   end

   // ****************************************************************
   // Bus read
   // ****************************************************************
   wire        rd_take  = s_axi_arvalid && !rvalid_r;
   wire        rd_stamp = s_axi_araddr[7] && (s_axi_araddr[1:0] == 2'h0);
   wire [31:0] pin_tx_w = {28'h0, tx_func_r, 3'h0};
   wire [31:0] pin_rx_w = {28'h0, rx_func_r, 3'h0};
   wire [31:0] cnt_rd   = standard_compat_mode ?
                          32'h0000_0000 : stamp_cnt_r;
   wire [31:0] mst_rd   = {16'h0, mb16_en_r, 15'h0};
   logic [31:0] rd_word;           // Selected read word
   logic        rd_hit;            // Read address mapped

   // Read selection
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      if (rd_stamp) begin
         rd_word = stamp_r[s_axi_araddr[6:2]];
      end else begin
         unique case (s_axi_araddr)
            OFS_IRQ_LINE:  rd_word = irq_line_r;
            OFS_PROTECT:   rd_word = protect_r;
            OFS_TX_PIN:    rd_word = pin_tx_w;
            OFS_RX_PIN:    rd_word = pin_rx_w;
            OFS_STAMP_CNT: rd_word = cnt_rd;
            OFS_MASTER:    rd_word = mst_rd;
            OFS_IRQ_MASK:  rd_word = irq_mask_r;
            OFS_RX_LOST:   rd_word = rx_lost_r;
            default:       rd_hit  = 1'b0;
         endcase
      end
   end

   // Read answer, one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_OKAY;
      end else if (rd_take) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_word;
         rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Handshake outputs
   assign s_axi_awready = !aw_have_r;
   assign s_axi_wready  = !w_have_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

endmodule : cmit_support

//--- cmit_support_chk.sv
// Port checker for the mailbox support block
`timescale 1ns/1ns
module cmit_support_chk (
   input wire logic aclk, aresetn, s_axi_arvalid, s_axi_arready,
   input wire logic s_axi_rvalid, s_axi_bvalid, s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic rx_store_req, rx_store_valid, rx_discard, tx_done,
   input wire logic interrupt_line_zero, interrupt_line_one,
   input wire logic counter_overflow_flag, transmit_pin, engine_rx
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_store_once: assert property (
      rx_store_req |=> rx_store_valid ^ rx_discard) else $error("no answer");
   chk_no_cause: assert property (
      !$past(rx_store_req) |-> !(rx_store_valid || rx_discard))
      else $error("store without request");
   chk_irq_cause: assert property (
      interrupt_line_zero || interrupt_line_one
      |-> $past(rx_store_valid || tx_done)) else $error("stray irq");
   chk_ovf_pulse: assert property (
      counter_overflow_flag |=> !counter_overflow_flag) else $error("ovf");
   chk_tx_idle: assert property (
      $past(!aresetn) |-> transmit_pin) else $error("tx pin driven");
   chk_rx_idle: assert property (
      $past(!aresetn) |-> engine_rx) else $error("rx pin passed");
   chk_read_next: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("rd");
   chk_resp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bresp dropped");
   // Main scenarios reached
   cover property (rx_discard);
   cover property (interrupt_line_one);
   cover property (counter_overflow_flag);
endmodule : cmit_support_chk
bind cmit_support cmit_support_chk u_cmit_support_chk (.*);

//--- cmit_support_test.sv
// Self-checking bench for the mailbox support block
`timescale 1ns/1ns
module cmit_support_test;
   import cmit_pkg::*;
   logic aclk=0, aresetn=0, s_axi_awvalid=0, s_axi_wvalid=0, s_axi_bready=0;
   logic s_axi_arvalid=0, s_axi_rready=0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_store_valid;
   logic [7:0] s_axi_awaddr=0, s_axi_araddr=0;
   logic [31:0] s_axi_wdata=0, s_axi_rdata, rx_match_mask=0, r;
   logic [31:0] receive_pending_bit=0, mailbox_direction=0, rnd_m, rnd_p;
   logic [6:0] exp_rx;
   logic [3:0] s_axi_wstrb=0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic protected_write_mode=0, standard_compat_mode=0, init_mode=0;
   logic sleep_mode=0, suspend_mode=0, can_sm_busy=0, bit_tick=0;
   logic rx_store_req=0, tx_done=0, rx_discard, engine_tx=1, engine_rx;
   logic [4:0] tx_mbox=0, rx_store_mbox;
   logic transmit_pin, receive_pin, node_drv=1, counter_overflow_flag;
   logic interrupt_line_zero, interrupt_line_one;
   int error_cnt=0, check_count=0;
   cmit_support u_cmit_support (.*);
   cmit_can_node u_cmit_can_node (.*);
   initial forever #5 aclk = ~aclk;
   initial begin
      #200000 error_cnt++;
      conclude;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // Lowest matching mailbox that is empty or unprotected takes the frame
   function automatic logic [6:0] pick(input logic [31:0] m, p, q);
      for (int i = 0; i < NUM_MBOX; i++) begin
         if (m[i] && !(p[i] && q[i])) return {2'h2, 5'(i)};
      end
      return 7'h20;
   endfunction : pick
   // Line select word is 2: mailbox 1 on line one, the rest on zero
   function automatic logic [1:0] exp_line(input logic [6:0] e);
      return e[6] ? {e[4:0] == 5'h01, e[4:0] != 5'h01} : 2'h0;
   endfunction : exp_line
   task chk(input logic [31:0] g, e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // One write, address and data offered together
   task wr(input logic [7:0] a, logic [31:0] d, logic [1:0] e = RESP_OKAY,
           logic [3:0] s = STRB_FULL);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      fork
         @(posedge aclk iff s_axi_awready) s_axi_awvalid <= 1'b0;
         @(posedge aclk iff s_axi_wready) s_axi_wvalid <= 1'b0;
      join
      @(posedge aclk iff s_axi_bvalid) s_axi_bready <= 1'b0;
      chk(s_axi_bresp, e);
   endtask : wr
   task rd(input logic [7:0] a, logic [31:0] d, logic [1:0] e = RESP_OKAY);
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      @(posedge aclk iff s_axi_arready) s_axi_arvalid <= 1'b0;
      @(posedge aclk iff s_axi_rvalid) s_axi_rready <= 1'b0;
      chk(s_axi_rdata, d);
      chk(s_axi_rresp, e);
   endtask : rd
   task ev(input logic t, d);
      @(posedge aclk) {bit_tick, tx_done} <= {t, d};
      @(posedge aclk) {bit_tick, tx_done} <= 2'h0;
   endtask : ev
   // Store request; answer and irq lines each one cycle later
   task rx(input logic [31:0] m, p, logic [6:0] e, logic [1:0] l);
      @(posedge aclk) {rx_store_req, rx_match_mask} <= {1'b1, m};
      receive_pending_bit <= p;
      @(posedge aclk) rx_store_req <= 1'b0;
      @(posedge aclk) chk({rx_store_valid, rx_discard, rx_store_mbox}, e);
      @(posedge aclk) chk({interrupt_line_one, interrupt_line_zero}, l);
   endtask : rx
   task conclude;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   initial begin
      r = lfsr(32'h353F);
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_STAMP_CNT, 0);
      wr(OFS_TX_PIN, '1);
      rd(OFS_TX_PIN, 0);
      protected_write_mode <= 1'b1;
      wr(OFS_TX_PIN, '1);
      rd(OFS_TX_PIN, 32'h8);
      wr(OFS_RX_PIN, 32'h8);
      {engine_tx, node_drv} <= 2'h0;
      repeat (6) @(posedge aclk);
      chk({transmit_pin, engine_rx}, 0);
      {engine_tx, node_drv} <= 2'h3;
      wr(OFS_PROTECT, 0, RESP_SLVERR, 4'h3);
      rd(8'h40, 0, RESP_SLVERR);
      $display("END pins");
      wr(OFS_STAMP_CNT, r);
      init_mode <= 1'b1;
      ev(1, 0);
      rd(OFS_STAMP_CNT, r);
      standard_compat_mode <= 1'b1;
      rd(OFS_STAMP_CNT, 0);
      {standard_compat_mode, init_mode, tx_mbox} <= 7'h05;
      ev(1, 1);
      rd(OFS_STAMP_BASE + 8'h14, r);
      protected_write_mode <= 1'b0;
      wr(OFS_STAMP_CNT, 0);
      rd(OFS_STAMP_CNT, r + 1);
      protected_write_mode <= 1'b1;
      wr(OFS_STAMP_CNT, '1);
      ev(1, 0);
      rd(OFS_STAMP_CNT, 0);
      wr(OFS_STAMP_CNT, 32'h8000_0005);
      wr(OFS_MASTER, 32'h4000);
      rd(OFS_STAMP_CNT, 32'h5);
      wr(OFS_STAMP_CNT, 32'h7FFF_FFFF);
      ev(1, 0);
      repeat (2) @(posedge aclk);
      chk(counter_overflow_flag, 1);
      rd(OFS_STAMP_CNT, 32'h8000_0000);
      $display("END counter");
      wr(OFS_IRQ_MASK, '1);
      wr(OFS_IRQ_LINE, 32'h2);
      wr(OFS_PROTECT, 32'h1);
      rx(3, 1, 7'h41, 2'h2);
      rx(1, 1, 7'h20, 2'h0);
      rd(OFS_RX_LOST, 0);
      wr(OFS_PROTECT, 0);
      rx(1, 1, 7'h40, 2'h1);
      rd(OFS_RX_LOST, 32'h1);
      rd(OFS_STAMP_BASE + 8'h04, 32'h8000_0000);
      // Random protection, match and pending sets
      repeat (8) begin
         r = lfsr(r);
         rnd_m = lfsr(r);
         rnd_p = lfsr(rnd_m);
         exp_rx = pick(rnd_m, rnd_p, r);
         wr(OFS_PROTECT, r);
         rx(rnd_m, rnd_p, exp_rx, exp_line(exp_rx));
         r = rnd_p;
      end
      $display("END receive");
      // Mailbox 16 transmit clears the counter, deferred while busy
      wr(OFS_MASTER, 32'h8000);
      {can_sm_busy, tx_mbox} <= 6'h30;
      ev(0, 1);
      rd(OFS_STAMP_CNT, 32'h8000_0000);
      can_sm_busy <= 1'b0;
      rd(OFS_STAMP_CNT, 0);
      $display("END sync");
      conclude;
   end
endmodule : cmit_support_test
